// file: hw/sbcr_top.sv
// sbcr_top: two-wire write-only receiver, control fields, test decode
// assumes: scl/sda come from pins and are synchronised here
//
// Overview of operation
// - transfer starts with write address c8
// - one or more data bytes follow address
// - data byte msb selects upper or lower
// - fixed bit layout of both data bytes
// - b1 forced zero, b0 forced one
// - single byte keeps other byte's fields
// - b2..b11 weigh 1..512 mhz plus 0.25
// - code 001 enables test pattern generator
// - code 010 turns rf oscillator, mixer off
// - code 011 over-modulates video carrier
// - 100/110 put clocks on port if bit 0
// - code 101 high-impedance tuning test
// - code 111 baseband out, oscillator off
// - port bit one sinks, zero floats
// - reference clock is crystal over 128
// - feedback divides oscillator by 8 times n
`timescale 1ns/1ns
module sbcr_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic xtal_tick,
   input wire logic osc_tick,
   output logic port_o,
   output logic port_oe,
   output logic [11:0] div_n,
   output logic [2:0] test_select,
   output logic port_drive_bit,
   output logic test_pattern_generator,
   output logic rf_osc_off,
   output logic rf_mixer_off,
   output logic over_modulate,
   output logic phase_detector_off,
   output logic tuning_transistor_off,
   output logic tuning_amplifier_output_low,
   output logic baseband_on_rf,
   output logic reference_clock,
   output logic divided_oscillator_clock
);
   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic scl_m_q, scl_s_q, scl_p_q; // scl first, second, previous
   logic sda_m_q, sda_s_q, sda_p_q; // sda first, second, previous
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end
   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;
   assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_ev = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   ////////////////////////////////////////////////////////////////
   // receive state machine
   typedef enum logic [2:0] {
      SBCR_IDLE = 3'b000, // waiting for start
      SBCR_ADDR = 3'b001, // shifting address byte
      SBCR_AACK = 3'b010, // driving address ack
      SBCR_DATA = 3'b011, // shifting data byte
      SBCR_DACK = 3'b100 // driving data ack
   } sbcr_state_t;
   sbcr_state_t state_q;
   logic [7:0] shift_q; // incoming byte
   logic [3:0] bit_q; // bits taken so far
   logic ack_q; // ack low being driven
   logic load_q; // one-cycle: data byte complete
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= SBCR_IDLE;
         shift_q <= 8'h00;
         bit_q <= 4'h0;
         ack_q <= 1'b0;
         load_q <= 1'b0;
      end else begin
         load_q <= 1'b0;
         if (start_ev) begin
            // start or repeated start
            state_q <= SBCR_ADDR;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
         end else if (stop_ev) begin
            state_q <= SBCR_IDLE;
            ack_q <= 1'b0;
         end else begin
            case (state_q)
               SBCR_ADDR, SBCR_DATA: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s_q};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     if (state_q == SBCR_ADDR) begin
                        // match write address only
                        if (shift_q == {sbcr_pkg::SLAVE_ADDR, 1'b0}) begin
                           state_q <= SBCR_AACK;
                           ack_q <= 1'b1;
                        end else begin
                           state_q <= SBCR_IDLE;
                        end
                     end else begin
                        state_q <= SBCR_DACK;
                        ack_q <= 1'b1;
                        load_q <= 1'b1;
                     end
                  end
               end
               SBCR_AACK, SBCR_DACK: begin
                  // release sda after the ack clock
                  if (scl_fall) begin
                     ack_q <= 1'b0;
                     state_q <= SBCR_DATA;
                  end
               end
               default: begin
                  state_q <= SBCR_IDLE;
               end
            endcase
         end
      end
   end
   assign sda_o = 1'b0;
   assign sda_oe = ack_q;

   ////////////////////////////////////////////////////////////////
   // control fields
   logic [6:0] upper_q; // divider b11..b5
   logic [6:0] lower_q; // selector, port, b4..b2
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         upper_q <= sbcr_pkg::UPPER_RESET;
         lower_q <= sbcr_pkg::LOWER_RESET;
      end else if (load_q) begin
         // msb steers the byte; the other keeps its value
         if (!shift_q[sbcr_pkg::BYTE_SEL_BIT]) begin
            upper_q <= shift_q[6:0];
         end else begin
            lower_q <= shift_q[6:0];
         end
      end
   end
   // b11..b5, b4..b2, fixed b1 b0; weight of b2 is 1 mhz
   assign div_n = {upper_q, lower_q[2:0], sbcr_pkg::DIV_LOW_FIXED};
   assign test_select = {lower_q[sbcr_pkg::TSEL_A_POS], lower_q[sbcr_pkg::TSEL_B_POS],
                         lower_q[sbcr_pkg::TSEL_C_POS]};
   assign port_drive_bit = lower_q[sbcr_pkg::PORT_POS];

   ////////////////////////////////////////////////////////////////
   // test mode decode
   always_comb begin
      test_pattern_generator = 1'b0;
      rf_osc_off = 1'b0;
      rf_mixer_off = 1'b0;
      over_modulate = 1'b0;
      phase_detector_off = 1'b0;
      tuning_transistor_off = 1'b0;
      tuning_amplifier_output_low = 1'b0;
      baseband_on_rf = 1'b0;
      case (sbcr_pkg::sbcr_mode_t'(test_select))
         sbcr_pkg::SBCR_PATTERN: test_pattern_generator = 1'b1;
         sbcr_pkg::SBCR_RF_OFF: begin
            rf_osc_off = 1'b1;
            rf_mixer_off = 1'b1;
         end
         sbcr_pkg::SBCR_BALANCE: over_modulate = 1'b1;
         sbcr_pkg::SBCR_HIZ: begin
            phase_detector_off = 1'b1;
            tuning_transistor_off = 1'b1;
            tuning_amplifier_output_low = 1'b1;
         end
         sbcr_pkg::SBCR_BASEBAND: begin
            phase_detector_off = 1'b1;
            rf_osc_off = 1'b1;
            baseband_on_rf = 1'b1;
         end
         default: begin
            // normal operation and clock routing modes
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // reference divider: crystal ticks over 128
   localparam int REF_W = $clog2(sbcr_pkg::REF_DIV); // msb toggles every half period
   logic [REF_W-1:0] ref_cnt_q; // crystal tick counter
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ref_cnt_q <= '0;
      end else if (xtal_tick) begin
         ref_cnt_q <= ref_cnt_q + REF_W'(1);
      end
   end
   assign reference_clock = ref_cnt_q[REF_W-1];

   // feedback divider, oscillator over 8 times n
   sbcr_divider #(
      .PRESCALE(sbcr_pkg::FB_PRESCALE)
   ) u_div (
      .clk(clk),
      .rst_b(rst_b),
      .osc_tick(osc_tick),
      .div_n(div_n),
      .div_out(divided_oscillator_clock)
   );

   ////////////////////////////////////////////////////////////////
   // open-collector port: enable high means sinking
   logic port_sink;
   always_comb begin
      port_sink = port_drive_bit;
      if (!port_drive_bit) begin
         if (test_select == sbcr_pkg::SBCR_REF_OUT) begin
            port_sink = ~reference_clock;
         end else if (test_select == sbcr_pkg::SBCR_DIV_OUT) begin
            port_sink = ~divided_oscillator_clock;
         end
      end
   end
   assign port_o = 1'b0;
   assign port_oe = port_sink;
endmodule

// file: hw/sbcr_pkg.sv
// sbcr_pkg: shared constants for the synthesizer bus control receiver
// assumes: nothing; every user writes sbcr_pkg::name
package sbcr_pkg;
   localparam logic [6:0] SLAVE_ADDR = 7'h64; // write address byte c8
   localparam int BYTE_SEL_BIT = 7; // msb picks the target byte
   localparam int TSEL_A_POS = 6; // selector bit a in lower byte
   localparam int TSEL_B_POS = 5; // selector bit b
   localparam int TSEL_C_POS = 4; // selector bit c
   localparam int PORT_POS = 3; // port drive bit
   localparam logic [6:0] UPPER_RESET = 7'h00; // divider b11..b5 reset
   localparam logic [6:0] LOWER_RESET = 7'h00; // lower byte fields reset
   localparam logic [1:0] DIV_LOW_FIXED = 2'h1; // b1 = 0, b0 = 1
   localparam int REF_DIV = 128; // crystal to reference divide
   localparam int FB_PRESCALE = 8; // fixed prescale ahead of n
   // test selector codes, written as {bit a, bit b, bit c}
   typedef enum logic [2:0] {
      SBCR_NORMAL = 3'b000,
      SBCR_PATTERN = 3'b001,
      SBCR_RF_OFF = 3'b010,
      SBCR_BALANCE = 3'b011,
      SBCR_REF_OUT = 3'b100,
      SBCR_HIZ = 3'b101,
      SBCR_DIV_OUT = 3'b110,
      SBCR_BASEBAND = 3'b111
   } sbcr_mode_t;
endpackage

// file: hw/sbcr_divider.sv
// sbcr_divider: programmable feedback divider with fixed prescale
// assumes: osc_tick is a one-cycle enable in the clk domain
`timescale 1ns/1ns
module sbcr_divider #(
   parameter int PRESCALE = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic osc_tick,
   input wire logic [11:0] div_n,
   output logic div_out
);
   localparam int CW = $clog2(PRESCALE) + 12; // wide enough for prescale times n
   logic [CW-1:0] cnt_q; // ticks into the current output period
   logic [CW-1:0] last; // last tick of the period
   // period is prescale times n ticks; n of zero wraps to the longest count
   assign last = CW'(PRESCALE) * CW'(div_n) - CW'(1);
   // high over the first half of each period, so n of one still toggles
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_q <= '0;
         div_out <= 1'b0;
      end else if (osc_tick) begin
         if (cnt_q >= last) begin
            cnt_q <= '0;
            div_out <= 1'b1;
         end else begin
            cnt_q <= cnt_q + CW'(1);
            if (cnt_q == (last >> 1)) begin
               div_out <= 1'b0;
            end
         end
      end
   end
endmodule

// file: tb/sbcr_checker.sv
// sbcr_checker: port properties of the bus control receiver
// assumes: bound to sbcr_top, one clock domain
`timescale 1ns/1ns
module sbcr_checker (
   input logic clk,
   input logic rst_b,
   input logic xtal_tick,
   input logic sda_oe,
   input logic port_oe,
   input logic [11:0] div_n,
   input logic [2:0] test_select,
   input logic port_drive_bit,
   input logic test_pattern_generator,
   input logic rf_osc_off,
   input logic over_modulate,
   input logic reference_clock
);
   localparam logic [7:0] HALF = 8'(sbcr_pkg::REF_DIV / 2); // ticks per level
   logic [7:0] n_q; // crystal ticks since last reference edge
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // tick count, restarted at each reference edge
   always_ff @(posedge clk) begin
      if (!rst_b) n_q <= 8'h00;
      else if ($changed(reference_clock)) n_q <= {7'h00, xtal_tick};
      else n_q <= n_q + {7'h00, xtal_tick};
   end
   property p_low; div_n[1:0] == sbcr_pkg::DIV_LOW_FIXED; endproperty
   a_low: assert property (p_low) else $error("fixed low bits wrong");
   property p_upd; !$stable(div_n) |-> sda_oe; endproperty
   a_upd: assert property (p_upd) else $error("divider moved outside ack");
   property p_pat; test_pattern_generator == (test_select == 3'h1); endproperty
   a_pat: assert property (p_pat) else $error("pattern decode");
   property p_rf; test_select == 3'h2 |-> rf_osc_off; endproperty
   a_rf: assert property (p_rf) else $error("rf off decode");
   property p_bal; over_modulate == (test_select == 3'h3); endproperty
   a_bal: assert property (p_bal) else $error("balance decode");
   property p_route; test_select == 3'h4 && !port_drive_bit |-> port_oe != reference_clock;
   endproperty
   a_route: assert property (p_route) else $error("reference not on port");
   property p_port;
      port_drive_bit || !test_select[2] || test_select[0] |-> port_oe == port_drive_bit;
   endproperty
   a_port: assert property (p_port) else $error("port state");
   property p_ref; $changed(reference_clock) |-> n_q == HALF; endproperty
   a_ref: assert property (p_ref) else $error("reference half period");
endmodule

// file: tb/sbcr_bm.sv
// sbcr_bm: bus master model writing frames to the receiver
// assumes: sda is the open-drain line, pulled up when free
`timescale 1ns/1ns
module sbcr_bm (
   input logic clk,
   output logic scl,
   output logic sda_drv,
   input logic sda
);
   initial {scl, sda_drv} = 2'h3; // idle, both lines released
   // wait n quarter bits, then step off the edge
   task automatic qw(input int n);
      repeat (4 * n) @(posedge clk);
      #1;
   endtask
   // start, bytes msb first each with an ack slot, stop
   task automatic frame(input logic [7:0] b[$], output logic [7:0] acks);
      acks = 8'h00;
      sda_drv = 1'b0; // start: data falls, clock high
      qw(1);
      scl = 1'b0;
      qw(1);
      foreach (b[i]) begin
         for (int k = 8; k >= 0; k--) begin
            sda_drv = (k > 0) ? b[i][k - 1] : 1'b1; // released for ack
            qw(1);
            scl = 1'b1;
            qw(2);
            if (k == 0) acks[i] = !sda;
            scl = 1'b0;
            qw(1);
         end
      end
      sda_drv = 1'b0;
      qw(1);
      scl = 1'b1;
      qw(1);
      sda_drv = 1'b1; // stop: data rises, clock high
      qw(1);
   endtask
endmodule

// file: tb/tb.sv
// tb: top bench, receiver against the master model, checker bound
// assumes: package, design, model and checker compiled first
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0, rst_b = 1'b0; // clock, sync reset
   logic xtal_tick = 1'b0, osc_tick = 1'b1; // rate enables
   logic scl, sda_drv, sda_oe, port_oe, port_drive_bit; // bus and port
   logic [11:0] div_n; // divider word
   logic [2:0] test_select; // selector field
   logic [7:0] acks; // acks of last frame
   int failures = 0, n_tests = 0;
   wire sda_level, port_level, div_clk, ref_clk; // driven pin levels, routed clocks
   wire [7:0] dec; // pattern, osc off, mixer off, overmod, pd off, fet off, amp low, baseband
   wire sda = sda_drv & (!sda_oe | sda_level); // open drain with pull-up
   wire port_pin = port_oe ? port_level : 1'b1; // open collector with pull-up
   // expected decode per selector code
   localparam logic [7:0] DEC_EXP [8] = '{8'h00, 8'h80, 8'h60, 8'h10, 8'h00, 8'h0e, 8'h00, 8'h49};
   always #4 clk = ~clk;
   always @(posedge clk) #1 {xtal_tick, osc_tick} = ~{xtal_tick, osc_tick};
   sbcr_top sbcr_top_inst (
      .clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_level), .sda_oe(sda_oe),
      .xtal_tick(xtal_tick), .osc_tick(osc_tick), .port_o(port_level), .port_oe(port_oe),
      .div_n(div_n), .test_select(test_select), .port_drive_bit(port_drive_bit),
      .test_pattern_generator(dec[7]), .rf_osc_off(dec[6]), .rf_mixer_off(dec[5]),
      .over_modulate(dec[4]), .phase_detector_off(dec[3]), .tuning_transistor_off(dec[2]),
      .tuning_amplifier_output_low(dec[1]), .baseband_on_rf(dec[0]),
      .reference_clock(ref_clk), .divided_oscillator_clock(div_clk)
   );
   sbcr_bm sbcr_bm_inst (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) failures++;
      if (got !== exp) $display("mismatch at %0t: got %h want %h", $time, got, exp);
   endtask
   task automatic end_of_test();
      if (failures == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_reset();
      chk(div_n, 12'h001);
      chk({6'h00, test_select, port_drive_bit, sda_oe, port_oe}, 12'h000);
      chk({2'h0, dec, port_pin, sda}, 12'h003);
   endtask
   task automatic t_both();
      sbcr_bm_inst.frame('{8'hc8, 8'h87, 8'h3a}, acks);
      chk({4'h0, acks}, 12'h007);
      chk({2'h0, div_n[11:2]}, 12'h1d7);
      sbcr_bm_inst.frame('{8'hc8, 8'h3b}, acks);
      chk(div_n, 12'h77d);
      sbcr_bm_inst.frame('{8'hc8, 8'h80}, acks);
      chk(div_n, 12'h761);
   endtask
   task automatic t_modes();
      for (int m = 0; m < 8; m++) begin
         sbcr_bm_inst.frame('{8'hc8, {1'b1, m[2:0], 4'h0}}, acks);
         repeat (200) @(posedge clk);
         #1 chk({9'h000, test_select}, 12'(m));
         chk({4'h0, dec}, {4'h0, DEC_EXP[m]});
      end
      sbcr_bm_inst.frame('{8'hc8, 8'h88}, acks);
      chk({10'h000, port_drive_bit, port_oe}, 12'h003);
      chk({11'h000, port_pin}, 12'h000);
   endtask
   task automatic t_refuse();
      sbcr_bm_inst.frame('{8'hc9, 8'h3f}, acks);
      chk({4'h0, acks}, 12'h000);
      chk(div_n, 12'h761);
   endtask
   // small n, divided clock routed to the port, then the port bit overrides
   task automatic t_clocks();
      time t0;
      sbcr_bm_inst.frame('{8'hc8, 8'h00, 8'he1}, acks);
      chk(div_n, 12'h005);
      @(posedge div_clk) t0 = $time;
      @(posedge div_clk) #1 chk({11'h000, port_pin}, 12'h001);
      chk(12'(($time - t0 - 1) / 8), 12'(2 * sbcr_pkg::FB_PRESCALE * 5));
      @(negedge div_clk) #1 chk({11'h000, port_pin}, 12'h000);
      @(posedge ref_clk) t0 = $time;
      @(posedge ref_clk) #1 chk(12'(($time - t0 - 1) / 8), 12'(2 * sbcr_pkg::REF_DIV));
      sbcr_bm_inst.frame('{8'hc8, 8'he9}, acks);
      @(posedge div_clk) #1 chk({11'h000, port_pin}, 12'h000);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      #1 t_reset();
      t_both();
      t_modes();
      t_refuse();
      t_clocks();
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      t_reset();
      end_of_test();
   end
   // watchdog against a hung bus
   initial begin
      #400000;
      failures++;
      end_of_test();
   end
endmodule
bind sbcr_top sbcr_checker sbcr_checker_inst (.clk(clk), .rst_b(rst_b), .xtal_tick(xtal_tick),
   .sda_oe(sda_oe), .port_oe(port_oe), .div_n(div_n), .test_select(test_select),
   .port_drive_bit(port_drive_bit), .test_pattern_generator(test_pattern_generator),
   .rf_osc_off(rf_osc_off), .over_modulate(over_modulate), .reference_clock(reference_clock));
